// ### shared/timer_pkg.sv
// constants shared by the up/down timer modules
package timer_pkg;

    // register byte addresses
    localparam logic [7:0] mode_addr   = 8'hb4;
    localparam logic [7:0] count_addr  = 8'hb8;
    localparam logic [7:0] reload_addr = 8'hbc;
    localparam int         addr_width  = 8;
    localparam int         data_width  = 32;

    // mode register layout and values after reset
    localparam int         reload_bit      = 7;
    localparam int         dir_hi_bit      = 6;
    localparam int         dir_lo_bit      = 5;
    localparam int         src_msb         = 2;
    localparam logic [7:0] mode_reset      = 8'h18;
    localparam logic [7:0] mode_fixed_ones = 8'h18;
    localparam logic [7:0] mode_write_mask = 8'he7;

    // counter and reload values after reset
    localparam logic [7:0] count_reset  = 8'h00;
    localparam logic [7:0] reload_reset = 8'h00;
    localparam logic [7:0] count_top    = 8'hff;
    localparam logic [7:0] count_bottom = 8'h00;

    // direction field codes
    localparam logic [1:0] dir_up   = 2'h0;
    localparam logic [1:0] dir_down = 2'h1;

    // prescaler: taps as powers of two, code 0 slowest
    localparam int         presc_width = 13;
    localparam int         tap_count   = 7;
    localparam int         tap_log2 [tap_count] = '{13, 11, 9, 6, 4, 2, 1};
    localparam logic [2:0] src_event   = 3'h7;
    localparam logic [12:0] presc_reset = 13'h0000;

endpackage

// ### shared/timer_link_if.sv
// signals passed between the timer top, its prescaler and its counter core
`timescale 1ns/1ps
interface timer_link_if;
    logic       tick;
    logic [2:0] src;
    logic       reload_en;
    logic [1:0] dir_sel;
    logic       dir_pin;
    logic [7:0] reload;
    logic [7:0] count;
    logic       wrap;

    modport source (input src, output tick);
    modport core   (input tick, reload_en, dir_sel, dir_pin, reload, output count, wrap);
    modport ctrl   (output src, reload_en, dir_sel, dir_pin, reload, input count, wrap, tick);
endinterface

// ### rtl/tick_prescaler.sv
// prescaler and count clock selection
`timescale 1ns/1ps
module tick_prescaler
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    // external event pin
    input  wire logic       event_clock_input,
    // to the counter core
    timer_link_if.source    link
);

    logic [presc_width-1:0] presc;
    logic [presc_width-1:0] next_presc;
    logic                   event_prev;
    logic                   next_event_prev;
    logic                   tick;
    logic                   next_tick;
    logic [tap_count-1:0]   tap_hit;

    // one pulse per tap period, when the low bits are all ones
    genvar i;
    generate
        for (i = 0; i < tap_count; i++) begin : g_tap
            assign tap_hit[i] = &presc[tap_log2[i]-1:0];
        end
    endgenerate

    // next prescaler, event history and tick
    always_comb begin
        next_presc      = presc + 13'h0001;
        next_event_prev = event_clock_input;
        if (link.src == src_event) begin
            next_tick = event_prev & ~event_clock_input;
        end else begin
            next_tick = tap_hit[link.src];
        end
    end

    // register state, frozen while ce is low
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc      <= presc_reset;
            event_prev <= 1'b0;
            tick       <= 1'b0;
        end else if (ce) begin
            presc      <= next_presc;
            event_prev <= next_event_prev;
            tick       <= next_tick;
        end
    end

    assign link.tick = tick;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_event_edge_tick: assert property (
        (ce && link.src == src_event && event_prev && !event_clock_input) |=> tick)
        else $error("falling event edge gave no count tick");

    chk_slow_tap_period: assert property (
        (tick && link.src == 3'h0 && $stable(link.src) && $past(ce)) |-> presc == 13'h0000)
        else $error("slowest tap ticked off its period");

    cov_event_tick: cover property (tick && link.src == src_event);

endmodule

// ### rtl/updown_counter.sv
// eight-bit up/down counter with wrap or auto-reload
`timescale 1ns/1ps
module updown_counter
    import timer_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_b,
    input  wire logic   ce,
    // mode, tick and count
    timer_link_if.core  link
);

    logic [7:0] count;
    logic [7:0] next_count;
    logic       wrap;
    logic       next_wrap;
    logic       count_down;

    // next count on each tick
    always_comb begin
        count_down = link.dir_sel[1] ? link.dir_pin : link.dir_sel[0];
        next_count = count;
        next_wrap  = 1'b0;
        if (link.tick) begin
            if (count_down) begin
                if (count == count_bottom) begin
                    next_wrap  = 1'b1;
                    next_count = link.reload_en ? link.reload : count_top;
                end else begin
                    next_count = count - 8'h01;
                end
            end else begin
                if (count == count_top) begin
                    next_wrap  = 1'b1;
                    next_count = link.reload_en ? link.reload : count_bottom;
                end else begin
                    next_count = count + 8'h01;
                end
            end
        end
    end

    // register count and wrap pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= count_reset;
            wrap  <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            wrap  <= next_wrap;
        end
    end

    assign link.count = count;
    assign link.wrap  = wrap;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_reload_on_wrap: assert property (
        (ce && link.tick && link.reload_en && (count == count_top || count == count_bottom)
         && (count_down == (count == count_bottom))) |=> count == $past(link.reload))
        else $error("auto-reload did not load the reload value");

    chk_free_wrap_up: assert property (
        (ce && link.tick && !link.reload_en && !count_down && count == count_top)
        |=> count == count_bottom && wrap)
        else $error("interval mode failed to wrap to zero");

    chk_pin_counts_down: assert property (
        (ce && link.tick && link.dir_sel[1] && link.dir_pin && count != count_bottom)
        |=> count == $past(count) - 8'h01)
        else $error("direction pin high did not count down");

    chk_fixed_up: assert property (
        (ce && link.tick && link.dir_sel == dir_up && count != count_top)
        |=> count == $past(count) + 8'h01)
        else $error("fixed up direction did not count up");

    cov_reload_wrap: cover property (wrap && link.reload_en);
    cov_pin_down:    cover property (link.tick && link.dir_sel[1] && link.dir_pin);

endmodule

// ### rtl/reloadable_updown_timer.sv
// eight-bit reloadable up/down timer with a classic wishbone register slave
//
// Summary of operation
// - mode register at 0xb4: reload bit, direction field, clock source; bits 4:3 read one
// - reload bit clear: counter runs freely and wraps on overflow or underflow
// - reload bit set: each overflow or underflow loads the counter from reload value
// - direction 00 up, 01 down, 1x follows pin: high down, low up
`timescale 1ns/1ps
module reloadable_updown_timer
    import timer_pkg::*;
(
    // clock, reset and clock enable
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,

    // wishbone slave
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [addr_width-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [data_width-1:0] dat_i,
    output logic      [data_width-1:0] dat_o,
    output logic                       ack_o,

    // timer pins
    input  wire logic                  event_clock_input,
    input  wire logic                  direction_select_pin,

    // wrap event
    output logic                       wrap_pulse
);

    // register state
    logic [7:0]            count_mode_control;
    logic [7:0]            next_count_mode_control;
    logic [7:0]            reload_value;
    logic [7:0]            next_reload_value;

    // bus state
    logic                  ack;
    logic                  next_ack;
    logic [data_width-1:0] rdata;
    logic [data_width-1:0] next_rdata;

    // decode
    logic                  bus_req;
    logic                  bus_write;
    logic                  hit_mode;
    logic                  hit_count;
    logic                  hit_reload;

    timer_link_if link ();

    // count clock source
    tick_prescaler u_prescaler (
        .clk               (clk),
        .rst_b             (rst_b),
        .ce                (ce),
        .event_clock_input (event_clock_input),
        .link              (link)
    );

    // counter core
    updown_counter u_counter (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .link  (link)
    );

    // mode fields out to the submodules
    assign link.src       = count_mode_control[src_msb:0];
    assign link.reload_en = count_mode_control[reload_bit];
    assign link.dir_sel   = count_mode_control[dir_hi_bit:dir_lo_bit];
    assign link.dir_pin   = direction_select_pin;
    assign link.reload    = reload_value;

    // address decode
    assign bus_req    = cyc_i & stb_i;
    assign hit_mode   = (adr_i == mode_addr);
    assign hit_count  = (adr_i == count_addr);
    assign hit_reload = (adr_i == reload_addr);

    // a write lands on the edge where the master sees ack
    assign bus_write  = bus_req & we_i & ack & sel_i[0];

    // next register values
    always_comb begin
        next_count_mode_control = count_mode_control;
        next_reload_value       = reload_value;
        if (bus_write && hit_mode) begin
            next_count_mode_control = (dat_i[7:0] & mode_write_mask)
                                    | mode_fixed_ones;
        end
        if (bus_write && hit_reload) begin
            next_reload_value = dat_i[7:0];
        end
    end

    // register the programmable registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_mode_control <= mode_reset;
            reload_value       <= reload_reset;
        end else if (ce) begin
            count_mode_control <= next_count_mode_control;
            reload_value       <= next_reload_value;
        end
    end

    // ack one cycle after the request, then drop; read data with it
    always_comb begin
        next_ack   = bus_req & ~ack;
        next_rdata = '0;
        if (bus_req && !ack) begin
            if (hit_mode) begin
                next_rdata = {24'h000000, count_mode_control};
            end else if (hit_count) begin
                next_rdata = {24'h000000, link.count};
            end else if (hit_reload) begin
                next_rdata = {24'h000000, reload_value};
            end
        end
    end

    // register the bus answer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else if (ce) begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign ack_o      = ack;
    assign dat_o      = rdata;
    assign wrap_pulse = link.wrap;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_mode_fixed_ones: assert property (
        count_mode_control[4:3] == 2'b11)
        else $error("unused mode bits do not read as one");

    chk_mode_write_lands: assert property (
        (ce && bus_write && hit_mode)
        |=> count_mode_control == (($past(dat_i[7:0]) & mode_write_mask) | mode_fixed_ones))
        else $error("mode write not stored as masked");

    chk_ack_single: assert property (
        (ce && bus_req && !ack) |=> ack ##1 (!ack || !$past(ce)))
        else $error("ack not a single cycle answer");

    chk_count_read_ro: assert property (
        (ce && bus_write && hit_count) |=> count_mode_control == $past(count_mode_control)
        && reload_value == $past(reload_value))
        else $error("write to count changed another register");

    cov_mode_write:   cover property (bus_write && hit_mode);
    cov_reload_write: cover property (bus_write && hit_reload);

endmodule

// ### bench/testbench.sv
// self-checking bench for the reloadable up/down timer
`timescale 1ns/1ps
module testbench;
    import timer_pkg::*;

    // design inputs and outputs
    logic                  clk;
    logic                  rst_b;
    logic                  ce;
    logic                  cyc_i;
    logic                  stb_i;
    logic                  we_i;
    logic [addr_width-1:0] adr_i;
    logic [3:0]            sel_i;
    logic [data_width-1:0] dat_i;
    logic [data_width-1:0] dat_o;
    logic                  ack_o;
    logic                  ev;
    logic                  dpin;
    logic                  wrap_pulse;

    // bench state
    int   err_count;
    int   checks_done;
    int   cycles;
    logic wrap_seen;
    logic [7:0] rd;
    logic [7:0] c1;

    reloadable_updown_timer dut (
        .clk                  (clk),
        .rst_b                (rst_b),
        .ce                   (ce),
        .cyc_i                (cyc_i),
        .stb_i                (stb_i),
        .we_i                 (we_i),
        .adr_i                (adr_i),
        .sel_i                (sel_i),
        .dat_i                (dat_i),
        .dat_o                (dat_o),
        .ack_o                (ack_o),
        .event_clock_input    (ev),
        .direction_select_pin (dpin),
        .wrap_pulse           (wrap_pulse)
    );

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // wrap monitor and hang guard
    always @(posedge clk) begin
        if (wrap_pulse === 1'b1) begin
            wrap_seen <= 1'b1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // compare an 8-bit value
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // compare the wrap flag
    task automatic check_wrap(input logic exp);
        checks_done = checks_done + 1;
        if (wrap_seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0t: wrap flag %b expected %b", $time, wrap_seen, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        do @(posedge clk); while (ack_o !== 1'b1);
        rd = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        check_val(rd, exp);
    endtask

    // n falling edges on the event input, each low-high-low
    task automatic pulses(input int n);
        repeat (n) begin
            ev <= 1'b1;
            repeat (2) @(posedge clk);
            ev <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // reset values, fixed bits and an unmapped place
    task automatic t_regs();
        rd_chk(mode_addr, 8'h18);
        rd_chk(count_addr, 8'h00);
        rd_chk(reload_addr, 8'h00);
        wb(1'b1, mode_addr, 8'hff);
        rd_chk(mode_addr, 8'hff);
        wb(1'b1, mode_addr, 8'h00);
        rd_chk(mode_addr, 8'h18);
        wb(1'b1, 8'hc0, 8'h77);
        rd_chk(8'hc0, 8'h00);
    endtask

    // interval mode counts up and wraps without reloading
    task automatic t_interval();
        wb(1'b1, reload_addr, 8'h55);
        wb(1'b1, mode_addr, 8'h07);
        wrap_seen = 1'b0;
        pulses(255);
        rd_chk(count_addr, 8'hff);
        check_wrap(1'b0);
        pulses(1);
        rd_chk(count_addr, 8'h00);
        check_wrap(1'b1);
    endtask

    // auto-reload on underflow, then pin-controlled direction
    task automatic t_reload_dir();
        wb(1'b1, mode_addr, 8'ha7);
        wrap_seen = 1'b0;
        pulses(1);
        rd_chk(count_addr, 8'h55);
        check_wrap(1'b1);
        pulses(1);
        rd_chk(count_addr, 8'h54);
        wb(1'b1, mode_addr, 8'hc7);
        dpin <= 1'b1;
        pulses(1);
        rd_chk(count_addr, 8'h53);
        dpin <= 1'b0;
        pulses(2);
        rd_chk(count_addr, 8'h55);
        wb(1'b1, mode_addr, 8'he7);
        dpin <= 1'b1;
        pulses(1);
        rd_chk(count_addr, 8'h54);
    endtask

    // refused writes and a frozen clock enable leave state alone
    task automatic t_refuse_ce();
        wb(1'b1, count_addr, 8'h99);
        rd_chk(count_addr, 8'h54);
        sel_i <= 4'h0;
        wb(1'b1, reload_addr, 8'h11);
        sel_i <= 4'h1;
        rd_chk(reload_addr, 8'h55);
        ce <= 1'b0;
        pulses(1);
        ce <= 1'b1;
        @(posedge clk);
        rd_chk(count_addr, 8'h54);
    endtask

    // prescaler tap divide by four
    task automatic t_tap();
        wb(1'b1, mode_addr, 8'h05);
        wb(1'b0, count_addr, 8'h00);
        c1 = rd;
        repeat (200) @(posedge clk);
        wb(1'b0, count_addr, 8'h00);
        rd = rd - c1;
        check_val(8'((rd >= 8'd49) && (rd <= 8'd53)), 8'h01);
    endtask

    // main sequence
    initial begin
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        wrap_seen = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'h1;
        dat_i = 32'h00000000;
        ev = 1'b0;
        dpin = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_interval();
        t_reload_dir();
        t_refuse_ce();
        t_tap();
        complete_run();
    end
endmodule
